/* hdl/csd_pkg.sv */
package csd_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;

	// register offsets
	localparam logic [7:0] OFF_CHAN_SEQ_CFG   = 8'h1b;
	localparam logic [7:0] OFF_SOFT_RESET     = 8'h1c;
	localparam logic [7:0] OFF_DRIVE_CHAN0    = 8'h1e;
	localparam logic [7:0] OFF_DRIVE_CHAN1    = 8'h1f;
	localparam logic [7:0] OFF_DRIVE_CHAN2    = 8'h20;
	localparam logic [7:0] OFF_DRIVE_CTRL     = 8'h40;

	// channel sequence config fields
	localparam int SCAN_EN_BIT     = 15;
	localparam int SCAN_ORDER_LSB  = 13;
	localparam int SEQ_RSVD_LSB    = 3;
	localparam int FILTER_LSB      = 0;
	localparam logic [9:0] SEQ_RSVD_RST = 10'h041;
	localparam logic [2:0] FILTER_RST   = 3'h7;

	// soft reset field
	localparam int SOFT_RST_BIT = 15;

	// drive register fields
	localparam int MANUAL_LSB = 11;
	localparam int CALIB_LSB  = 6;
	localparam logic [4:0] DRIVE_RST = 5'h00;

	// drive control register fields
	localparam int SINGLE_CHAN_LSB = 14;
	localparam int OVERRIDE_BIT    = 12;
	localparam int AMP_DIS_BIT     = 10;

	// filter bandwidth codes
	localparam logic [2:0] FILT_1MHZ   = 3'h1;
	localparam logic [2:0] FILT_3P3MHZ = 3'h4;
	localparam logic [2:0] FILT_10MHZ  = 3'h5;
	localparam logic [2:0] FILT_33MHZ  = 3'h7;

	// scan order codes
	localparam logic [1:0] ORDER_CH01   = 2'h0;
	localparam logic [1:0] ORDER_CH012  = 2'h1;
	localparam logic [1:0] ORDER_CH0123 = 2'h2;
	localparam logic [1:0] ORDER_CH01B  = 2'h3;

	typedef enum logic [1:0] {
		CSD_BW_1MHZ,
		CSD_BW_3P3MHZ,
		CSD_BW_10MHZ,
		CSD_BW_33MHZ
	} csd_bw_t;

	typedef struct packed {
		logic       scan_enable;
		logic [1:0] scan_order;
		logic [9:0] reserved;
		logic [2:0] filter_bw;
	} csd_seq_cfg_t;

	typedef struct packed {
		logic [4:0] manual_drive_level;
		logic [4:0] calibrated_drive_level;
	} csd_drive_t;

	typedef struct packed {
		logic       valid;
		logic [1:0] chan;
		logic [4:0] level;
	} csd_cal_upd_t;

endpackage

/* hdl/csd_channel_scan_drive_config.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - scan off: convert continuously on the single selected channel.
// - scan on: run auto-scan over channels chosen by scan order.
// - auto-scan converts each sequence channel once, then restarts from channel 0.
// - scan order 00/11 ch0-1, 01 ch0-2, 10 ch0-3.
// - filter codes 001 1 MHz, 100 3.3, 101 10, 111 33 MHz; reset 111.
// - writing one to soft reset top bit resets the whole device; here the read data register clears only on hard reset.
// - soft reset trigger bit always reads zero.
// - manual drive level sets drive current during settling and conversion.
// - calibrated drive level is read-only, holds initial drive, resets zero.
// - calibrated level updates after each amplitude correction unless disabled.
// - single channel select codes 00..11 choose channels 0..3.
// - amplitude correction disable stops correction, freezes calibrated levels.
// - manual override switches conversion drive to per-channel manual levels.
module csd_channel_scan_drive_config #(
	parameter int NUM_CHAN = 4
) (
	input  wire logic                i_sys_clk,
	input  wire logic                i_rst,
	input  wire logic [7:0]          i_addr,
	input  wire logic [15:0]         i_wdata,
	input  wire logic                i_wr,
	input  wire logic                i_rd,
	output logic      [15:0]         o_rdata,
	input  wire logic                i_conv_done,
	input  wire logic                i_cal_valid,
	input  wire logic [1:0]          i_cal_chan,
	input  wire logic [4:0]          i_cal_level,
	output logic      [1:0]          o_single_channel_select,
	output logic                     o_scan_enable,
	output logic                     o_manual_drive_override,
	output logic                     o_amplitude_correction_disable,
	output logic      [4:0]          o_manual_drive_level,
	output csd_pkg::csd_bw_t         o_filter_bw,
	output logic                     o_soft_reset
);

	if (NUM_CHAN != 2 && NUM_CHAN != 4) begin : g_bad_num_chan
		$error("NUM_CHAN must be 2 or 4");
	end

	// drive registers exist for channels 0..2 only; ch3 lives elsewhere
	localparam int NDRV = 3;

	////////////////////////////////////////////////////////////////////////////
	// register state
	csd_pkg::csd_seq_cfg_t seq_q, seq_d;
	csd_pkg::csd_drive_t   drv_q [NDRV];
	csd_pkg::csd_drive_t   drv_d [NDRV];
	logic [1:0]            single_q, single_d;
	logic                  override_q, override_d;
	logic                  amp_dis_q, amp_dis_d;
	logic                  srst_q, srst_d;
	logic [15:0]           rdata_q, rdata_d;
	logic [1:0]            chan_q, chan_d;
	logic [1:0]            last_chan;
	logic                  full_rst;

	// soft reset is registered so the write completes before state clears
	assign full_rst = i_rst | srst_q;

	always_comb begin
		seq_d      = seq_q;
		single_d   = single_q;
		override_d = override_q;
		amp_dis_d  = amp_dis_q;
		srst_d     = 1'b0;
		for (int i = 0; i < NDRV; i++)
			drv_d[i] = drv_q[i];
		if (i_cal_valid && !amp_dis_q && i_cal_chan < 2'(NDRV))
			drv_d[i_cal_chan].calibrated_drive_level = i_cal_level;
		// writes during the soft reset pulse are lost, so the pulse cannot stretch
		if (i_wr && !srst_q) begin
			unique case (i_addr)
				csd_pkg::OFF_CHAN_SEQ_CFG: seq_d = i_wdata;
				csd_pkg::OFF_SOFT_RESET:
					srst_d = i_wdata[csd_pkg::SOFT_RST_BIT];
				csd_pkg::OFF_DRIVE_CHAN0:
					drv_d[0].manual_drive_level = i_wdata[csd_pkg::MANUAL_LSB +: 5];
				csd_pkg::OFF_DRIVE_CHAN1:
					drv_d[1].manual_drive_level = i_wdata[csd_pkg::MANUAL_LSB +: 5];
				csd_pkg::OFF_DRIVE_CHAN2:
					drv_d[2].manual_drive_level = i_wdata[csd_pkg::MANUAL_LSB +: 5];
				csd_pkg::OFF_DRIVE_CTRL: begin
					single_d   = i_wdata[csd_pkg::SINGLE_CHAN_LSB +: 2];
					override_d = i_wdata[csd_pkg::OVERRIDE_BIT];
					amp_dis_d  = i_wdata[csd_pkg::AMP_DIS_BIT];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (full_rst) begin
			seq_q      <= {1'b0, 2'h0, csd_pkg::SEQ_RSVD_RST, csd_pkg::FILTER_RST};
			single_q   <= 2'h0;
			override_q <= 1'b0;
			amp_dis_q  <= 1'b0;
			for (int i = 0; i < NDRV; i++)
				drv_q[i] <= '{csd_pkg::DRIVE_RST, csd_pkg::DRIVE_RST};
		end else begin
			seq_q      <= seq_d;
			single_q   <= single_d;
			override_q <= override_d;
			amp_dis_q  <= amp_dis_d;
			for (int i = 0; i < NDRV; i++)
				drv_q[i] <= drv_d[i];
		end
	end

	// trigger only cleared by hard reset; otherwise it self-clears next cycle
	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			srst_q <= 1'b0;
		else
			srst_q <= srst_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// read path
	always_comb begin
		rdata_d = 16'h0000;
		if (i_rd) begin
			unique case (i_addr)
				csd_pkg::OFF_CHAN_SEQ_CFG: rdata_d = seq_q;
				csd_pkg::OFF_SOFT_RESET:   rdata_d = 16'h0000;
				csd_pkg::OFF_DRIVE_CHAN0:  rdata_d = {drv_q[0], 6'h00};
				csd_pkg::OFF_DRIVE_CHAN1:  rdata_d = {drv_q[1], 6'h00};
				csd_pkg::OFF_DRIVE_CHAN2:  rdata_d = {drv_q[2], 6'h00};
				csd_pkg::OFF_DRIVE_CTRL: begin
					rdata_d[csd_pkg::SINGLE_CHAN_LSB +: 2] = single_q;
					rdata_d[csd_pkg::OVERRIDE_BIT]         = override_q;
					rdata_d[csd_pkg::AMP_DIS_BIT]          = amp_dis_q;
				end
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			rdata_q <= 16'h0000;
		else
			rdata_q <= rdata_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// channel sequencer
	always_comb begin
		unique case (seq_q.scan_order)
			csd_pkg::ORDER_CH012:  last_chan = 2'h2;
			csd_pkg::ORDER_CH0123: last_chan = 2'h3;
			default:               last_chan = 2'h1;
		endcase
		// two-channel part: clamp longer sequences to ch0-1
		if (NUM_CHAN == 2)
			last_chan = 2'h1;
	end

	always_comb begin
		chan_d = chan_q;
		if (!seq_q.scan_enable)
			chan_d = single_q;
		else if (chan_q > last_chan)
			chan_d = 2'h0;
		else if (i_conv_done)
			chan_d = (chan_q == last_chan) ? 2'h0 : chan_q + 2'h1;
	end

	always_ff @(posedge i_sys_clk) begin
		if (full_rst)
			chan_q <= 2'h0;
		else
			chan_q <= chan_d;
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	always_comb begin
		unique case (seq_q.filter_bw)
			csd_pkg::FILT_1MHZ:   o_filter_bw = csd_pkg::CSD_BW_1MHZ;
			csd_pkg::FILT_3P3MHZ: o_filter_bw = csd_pkg::CSD_BW_3P3MHZ;
			csd_pkg::FILT_10MHZ:  o_filter_bw = csd_pkg::CSD_BW_10MHZ;
			default:              o_filter_bw = csd_pkg::CSD_BW_33MHZ;
		endcase
	end

	always_comb begin
		o_manual_drive_level = 5'h00;
		if (chan_q < 2'(NDRV))
			o_manual_drive_level = drv_q[chan_q].manual_drive_level;
	end

	assign o_rdata                        = rdata_q;
	assign o_single_channel_select                  = chan_q;
	assign o_scan_enable                  = seq_q.scan_enable;
	assign o_manual_drive_override        = override_q;
	assign o_amplitude_correction_disable = amp_dis_q;
	assign o_soft_reset                   = srst_q;

endmodule // csd_channel_scan_drive_config

/* verification/csd_chk.sv */
`timescale 1ns/1ps
module csd_chk #(
	parameter int NUM_CHAN = 4
) (
	input logic             i_sys_clk,
	input logic             i_rst,
	input logic [7:0]       i_addr,
	input logic [15:0]      i_wdata,
	input logic             i_wr,
	input logic             i_rd,
	input logic [15:0]      o_rdata,
	input logic             i_conv_done,
	input logic [1:0]       o_single_channel_select,
	input logic             o_scan_enable,
	input logic             o_manual_drive_override,
	input logic             o_amplitude_correction_disable,
	input logic [4:0]       o_manual_drive_level,
	input csd_pkg::csd_bw_t o_filter_bw,
	input logic             o_soft_reset
);
	// a write landing while the pulse is high is lost, so it is not a request
	logic sr_req_q;
	always_ff @(posedge i_sys_clk)
		sr_req_q <= !i_rst && i_wr && i_addr == 8'h1c && i_wdata[15] && !o_soft_reset;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);
	soft_pulse_a: assert property (sr_req_q |-> o_soft_reset)
		else $error("soft reset not pulsed");
	soft_once_a: assert property (o_soft_reset |=> !o_soft_reset)
		else $error("soft reset not self clearing");
	soft_clear_a: assert property (o_soft_reset |=> !o_scan_enable && !o_manual_drive_override
		&& !o_amplitude_correction_disable && o_filter_bw == csd_pkg::CSD_BW_33MHZ)
		else $error("soft reset left state");
	soft_read_a: assert property ($past(i_rd) && $past(i_addr) == 8'h1c |-> o_rdata == 16'h0000)
		else $error("trigger read not zero");
	scan_step_a: assert property (o_scan_enable && i_conv_done && !i_wr && o_single_channel_select == 2'h0
		|=> o_single_channel_select == 2'h1) else $error("scan did not step");
	scan_wrap_a: assert property (o_scan_enable && i_conv_done && !i_wr && o_single_channel_select == 2'h3
		|=> o_single_channel_select == 2'h0) else $error("scan did not wrap");
	scan_hold_a: assert property (o_scan_enable && $past(o_scan_enable) && !i_conv_done && !i_wr
		|=> $stable(o_single_channel_select)) else $error("scan moved without done");
	single_hold_a: assert property (!o_scan_enable && !i_wr && !$past(i_wr) && !o_soft_reset
		|=> $stable(o_single_channel_select)) else $error("single channel moved");
	ch3_level_a: assert property (o_single_channel_select == 2'h3 && $stable(o_single_channel_select)
		|-> o_manual_drive_level == 5'h00) else $error("channel 3 level not zero");
	cover property (o_soft_reset);
	cover property (o_scan_enable && i_conv_done && o_single_channel_select == 2'h3);
	cover property (o_manual_drive_override && o_single_channel_select == 2'h2);
endmodule // csd_chk

bind csd_channel_scan_drive_config csd_chk #(.NUM_CHAN(NUM_CHAN)) csd_chk_i (.*);

/* verification/tb_channel_scan_drive_config.sv */
`timescale 1ns/1ps
module tb_channel_scan_drive_config;
	logic             i_sys_clk = 0, i_rst = 1, i_wr = 0, i_rd = 0, rd_seen = 0;
	logic             i_conv_done = 0, i_cal_valid = 0, o_soft_reset, o_scan_enable;
	logic             o_manual_drive_override, o_amplitude_correction_disable;
	logic [7:0]       i_addr = 8'h00, rnd = 8'h2c;
	logic [15:0]      i_wdata = 16'h0000, o_rdata;
	logic [1:0]       i_cal_chan = 2'h0, o_single_channel_select, last;
	logic [4:0]       i_cal_level = 5'h00, o_manual_drive_level, man [4];
	logic [2:0]       fc [4] = '{3'h1, 3'h4, 3'h5, 3'h7};
	csd_pkg::csd_bw_t o_filter_bw;
	logic [15:0]      exq [$];
	int               errors = 0, total_checks = 0, cycles = 0;

	csd_channel_scan_drive_config #(.NUM_CHAN(4)) csd_channel_scan_drive_config_i (.*);

	initial forever #50 i_sys_clk = ~i_sys_clk;
	////////////////////////////////////////
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("errors=%0d total_checks=%0d", errors, total_checks);
		if (errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
		@(posedge i_sys_clk);
		i_wr <= wr;
		i_rd <= !wr;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_sys_clk);
		i_wr <= 1'b0;
		i_rd <= 1'b0;
	endtask
	// expectation queued before the strobe so the monitor never pops an empty queue
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exq.push_back(e);
		bus(1'b0, a, 16'h0000);
	endtask
	task automatic pulse(input logic cv, input logic [1:0] c, input logic [4:0] l);
		@(posedge i_sys_clk);
		i_conv_done <= !cv;
		i_cal_valid <= cv;
		i_cal_chan <= c;
		i_cal_level <= l;
		@(posedge i_sys_clk);
		i_conv_done <= 1'b0;
		i_cal_valid <= 1'b0;
		@(negedge i_sys_clk);
	endtask
	////////////////////////////////////////
	always @(posedge i_sys_clk) begin
		rd_seen <= i_rd;
		cycles++;
		if (cycles == 5000) begin
			errors++;
			report_and_stop();
		end
	end
	always @(negedge i_sys_clk)
		if (rd_seen)
			chk(o_rdata, exq.pop_front());
	////////////////////////////////////////
	initial begin
		repeat (12) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		rd(8'h1b, 16'h020f);
		rd(8'h1c, 16'h0000);
		rd(8'h21, 16'h0000);
		for (int c = 0; c < 3; c++) begin
			rnd = lfsr(rnd);
			man[c] = rnd[4:0];
			bus(1'b1, 8'h1e + c[7:0], {rnd[4:0], 11'h7ff});
			rd(8'h1e + c[7:0], {rnd[4:0], 11'h000});
		end
		man[3] = 5'h00;
		rnd = lfsr(rnd);
		pulse(1'b1, 2'h1, rnd[4:0]);
		rd(8'h1f, {man[1], rnd[4:0], 6'h00});
		bus(1'b1, 8'h40, 16'h0400);
		pulse(1'b1, 2'h1, ~rnd[4:0]);
		rd(8'h1f, {man[1], rnd[4:0], 6'h00});
		chk(16'(o_amplitude_correction_disable), 16'h0001);
		for (int k = 0; k < 4; k++) begin
			bus(1'b1, 8'h1b, {3'h0, 10'h041, fc[k]});
			repeat (2) @(negedge i_sys_clk);
			chk(16'(o_filter_bw), 16'(k));
		end
		for (int c = 0; c < 4; c++) begin
			bus(1'b1, 8'h40, {c[1:0], 14'h1000});
			pulse(1'b0, 2'h0, 5'h00);
			chk(16'(o_single_channel_select), 16'(c));
			chk(16'(o_manual_drive_level), 16'(man[c]));
		end
		chk(16'(o_manual_drive_override), 16'h0001);
		bus(1'b1, 8'h40, 16'h0000);
		// twelve steps return every order to channel 0 for the next pass
		for (int q = 0; q < 4; q++) begin
			bus(1'b1, 8'h1b, {1'b1, q[1:0], 13'h020f});
			last = (q == 1) ? 2'h2 : (q == 2) ? 2'h3 : 2'h1;
			for (int n = 1; n <= 12; n++) begin
				pulse(1'b0, 2'h0, 5'h00);
				chk(16'(o_single_channel_select), 16'(n % (last + 1)));
			end
		end
		bus(1'b1, 8'h1c, 16'h8000);
		rd(8'h1c, 16'h0000);
		rd(8'h1b, 16'h020f);
		rd(8'h1f, 16'h0000);
		chk(16'(o_scan_enable), 16'h0000);
		repeat (2) @(negedge i_sys_clk);
		report_and_stop();
	end
endmodule // tb_channel_scan_drive_config
